// ==== hpb_pkg.sv ====
// Package for the host processor bus port: widths, sync depth, access types
package hpb_pkg;
   // ********************************************************************
   // Widths and timing
   // ********************************************************************
   localparam int HPB_DATA_W = 16;
   localparam int HPB_ADDR_W = 12;
   localparam int HPB_SYNC_STAGES = 3;
   localparam logic [15:0] HPB_RDATA_RST = 16'h0000;
   localparam logic [11:0] HPB_ADDR_RST = 12'h000;

   // ********************************************************************
   // Strobe styles and access kinds
   // ********************************************************************
   typedef enum logic {
      HPB_STYLE_RW = 1'b0,     // Single read/not-write line with chip select
      HPB_STYLE_STROBE = 1'b1  // Separate write and read strobes
   } hpb_style_e;

   // Access state: idle, read, write; Gray order idle->read and idle->write
   typedef enum logic [1:0] {
      HPB_IDLE = 2'b00,
      HPB_READ = 2'b01,
      HPB_WRITE = 2'b10
   } hpb_state_e;

   // Synchronised host pins
   typedef struct packed {
      logic cs_n;
      logic rnw_wr_n;
      logic oe_rd_n;
   } hpb_pins_s;

   // Request towards the internal register and memory space
   typedef struct packed {
      logic wr;
      logic rd;
      logic [11:0] addr;
      logic [15:0] wdata;
   } hpb_req_s;
endpackage : hpb_pkg

// ==== hpb_port.sv ====
// Host processor bus port: pin synchronisers, strobe decode and data bus drive
`timescale 1ns/1ps
module hpb_port
   import hpb_pkg::*;
#(
   parameter int DATA_W = HPB_DATA_W,
   parameter int ADDR_W = HPB_ADDR_W
) (
   // Clock and reset
   input wire logic clock_in,
   input wire logic rstn_in,
   // Static configuration
   input wire logic style_strobe_in,
   // Host pins
   input wire logic [ADDR_W-1:0] host_addr_in,
   input wire logic [DATA_W-1:0] host_data_in,
   output logic [DATA_W-1:0] host_data_out,
   output logic host_data_oe_out,
   input wire logic host_cs_n_in,
   input wire logic host_rnw_wr_n_in,
   input wire logic host_oe_rd_n_in,
   output logic host_irq_n_out,
   output logic host_irq_oe_out,
   // Internal side
   input wire logic irq_pending_in,
   input wire logic [DATA_W-1:0] int_rdata_in,
   output logic int_wr_out,
   output logic int_rd_out,
   output logic [ADDR_W-1:0] int_addr_out,
   output logic [DATA_W-1:0] int_wdata_out
);

   // ********************************************************************
   // Pin synchronisers
   // ********************************************************************
   // Three stages per pin; a change counts once stages two and three agree
   hpb_pins_s s1_ff, s2_ff, s3_ff, pins_ff;
   hpb_pins_s nxt_pins;
   logic [ADDR_W-1:0] addr_s1_ff, addr_s2_ff, addr_s3_ff, addr_flt_ff;
   logic [ADDR_W-1:0] nxt_addr_flt;
   logic [DATA_W-1:0] wd_s1_ff, wd_s2_ff, wd_s3_ff, wd_flt_ff;
   logic [DATA_W-1:0] nxt_wd_flt;
   logic irq_n_ff;
   hpb_style_e style_ff;
   hpb_state_e state_ff, nxt_state;
   logic [DATA_W-1:0] rdata_ff;
   logic drive_ff, irq_ff, wr_ff, rd_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [DATA_W-1:0] wdata_ff;

   wire hpb_pins_s pin_now = '{cs_n: host_cs_n_in, rnw_wr_n: host_rnw_wr_n_in,
                               oe_rd_n: host_oe_rd_n_in};

   // Agreement filter shared by strobes, address and data: a bit moves only where
   // stages two and three agree, otherwise it keeps its last filtered value.
   // Limitation: words up to 32 bits, enough for the 12-bit address and 16-bit data
   function automatic logic [31:0] agree_bits(input logic [31:0] s2, input logic [31:0] s3,
      input logic [31:0] held);
      agree_bits = (s2 & s3) | (held & (s2 | s3));
   endfunction : agree_bits

   // Same filter on every pin group, so a word and its strobe reach the decode together
   // and a write never catches data that the host has already withdrawn
   wire logic [31:0] pins_agree = agree_bits(32'(s2_ff), 32'(s3_ff), 32'(pins_ff));
   wire logic [31:0] addr_agree = agree_bits(32'(addr_s2_ff), 32'(addr_s3_ff),
                                             32'(addr_flt_ff));
   wire logic [31:0] wd_agree = agree_bits(32'(wd_s2_ff), 32'(wd_s3_ff),
                                           32'(wd_flt_ff));
   assign nxt_pins = hpb_pins_s'(pins_agree[2:0]);
   assign nxt_addr_flt = addr_agree[ADDR_W-1:0];
   assign nxt_wd_flt = wd_agree[DATA_W-1:0];

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         s1_ff <= '1;
         s2_ff <= '1;
         s3_ff <= '1;
         pins_ff <= '1;
      end else begin
         s1_ff <= pin_now;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         pins_ff <= nxt_pins;
      end
   end

   // Address and data take the same three stages and filter as the strobes
   // Their filtered copies line up edge for edge with the filtered strobes
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         addr_s1_ff <= HPB_ADDR_RST;
         addr_s2_ff <= HPB_ADDR_RST;
         addr_s3_ff <= HPB_ADDR_RST;
         addr_flt_ff <= HPB_ADDR_RST;
         wd_s1_ff <= HPB_RDATA_RST;
         wd_s2_ff <= HPB_RDATA_RST;
         wd_s3_ff <= HPB_RDATA_RST;
         wd_flt_ff <= HPB_RDATA_RST;
      end else begin
         addr_s1_ff <= host_addr_in;
         addr_s2_ff <= addr_s1_ff;
         addr_s3_ff <= addr_s2_ff;
         addr_flt_ff <= nxt_addr_flt;
         wd_s1_ff <= host_data_in;
         wd_s2_ff <= wd_s1_ff;
         wd_s3_ff <= wd_s2_ff;
         wd_flt_ff <= nxt_wd_flt;
      end
   end

   // ********************************************************************
   // Style and access decode
   // ********************************************************************
   // Style is captured only while idle, so a change mid-access cannot split it
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         style_ff <= HPB_STYLE_RW;
      end else if (state_ff == HPB_IDLE) begin
         style_ff <= hpb_style_e'(style_strobe_in);
      end
   end

   wire logic selected = !pins_ff.cs_n;
   // Read/not-write style: output-enable pin is held at ground and not looked at
   wire logic rw_read = selected && pins_ff.rnw_wr_n;
   wire logic rw_write = selected && !pins_ff.rnw_wr_n;
   wire logic st_write = selected && !pins_ff.rnw_wr_n && pins_ff.oe_rd_n;
   wire logic st_read = selected && !pins_ff.oe_rd_n && pins_ff.rnw_wr_n;
   wire logic want_read = (style_ff == HPB_STYLE_STROBE) ? st_read : rw_read;
   wire logic want_write = (style_ff == HPB_STYLE_STROBE) ? st_write : rw_write;

   // ********************************************************************
   // Access state machine
   // ********************************************************************
   // One internal strobe per access; the port waits for the host to end it
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         HPB_IDLE: begin
            if (want_read) begin
               nxt_state = HPB_READ;
            end else if (want_write) begin
               nxt_state = HPB_WRITE;
            end
         end
         HPB_READ: begin
            if (!want_read) begin
               nxt_state = HPB_IDLE;
            end
         end
         HPB_WRITE: begin
            if (!want_write) begin
               nxt_state = HPB_IDLE;
            end
         end
         default: begin
            nxt_state = HPB_IDLE;
         end
      endcase
   end

   wire logic start_rd = (state_ff == HPB_IDLE) && want_read;
   // Write commits at the end of the strobe, when the data is surely stable
   wire logic end_wr = (state_ff == HPB_WRITE) && !want_write;
   // Capture only while the filtered strobe still stands, never on the closing edge
   wire logic wr_held = (state_ff == HPB_WRITE) && want_write;

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         state_ff <= HPB_IDLE;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         addr_ff <= HPB_ADDR_RST;
         wdata_ff <= HPB_RDATA_RST;
      end else begin
         state_ff <= nxt_state;
         wr_ff <= end_wr;
         rd_ff <= start_rd;
         if (start_rd || wr_held) begin
            addr_ff <= addr_flt_ff;
         end
         if (wr_held) begin
            wdata_ff <= wd_flt_ff;
         end
      end
   end

   // ********************************************************************
   // Data bus drive and interrupt
   // ********************************************************************
   // Read data is latched the cycle after the internal read strobe
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         rdata_ff <= HPB_RDATA_RST;
         drive_ff <= 1'b0;
         irq_ff <= 1'b0;
         irq_n_ff <= 1'b1;
      end else begin
         if (rd_ff) begin
            rdata_ff <= int_rdata_in;
         end
         drive_ff <= (state_ff == HPB_READ) && want_read;
         irq_ff <= irq_pending_in;
         // Level mirrors the pull, so a board that ignores the enable still reads it right
         irq_n_ff <= !irq_pending_in;
      end
   end

   assign host_data_out = rdata_ff;
   assign host_data_oe_out = drive_ff;
   assign host_irq_n_out = irq_n_ff; // Low whenever the line is pulled
   assign host_irq_oe_out = irq_ff;
   assign int_wr_out = wr_ff;
   assign int_rd_out = rd_ff;
   assign int_addr_out = addr_ff;
   assign int_wdata_out = wdata_ff;
endmodule : hpb_port

// ==== hpb_port_props.sv ====
// Checker for the host bus port outputs
`timescale 1ns/1ps
module hpb_port_props
   import hpb_pkg::*;
(
   // Clock, reset and watched ports
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic host_cs_n_in,
   input wire logic irq_pending_in,
   input wire logic [15:0] host_data_out,
   input wire logic host_data_oe_out,
   input wire logic host_irq_n_out,
   input wire logic host_irq_oe_out,
   input wire logic int_wr_out,
   input wire logic int_rd_out
);
   // ****************
   // Properties
   // ****************
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rstn_in);
   property p_irq_on; irq_pending_in |=> host_irq_oe_out; endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq not pulled");
   property p_irq_off; !irq_pending_in |=> !host_irq_oe_out; endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq not released");
   property p_irq_low; host_irq_n_out == !host_irq_oe_out; endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq level wrong");
   property p_rd_drive; int_rd_out |=> host_data_oe_out; endproperty
   a_rd_drive: assert property (p_rd_drive) else $error("read not driven");
   property p_rd_pulse; int_rd_out |=> !int_rd_out; endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse long");
   property p_wr_quiet; int_wr_out |-> !host_data_oe_out && !int_rd_out; endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("drive during write");
   // Eight quiet cycles cover the filter and the write commit delay
   property p_cs_idle; host_cs_n_in [*8] |-> !int_rd_out && !int_wr_out && !host_data_oe_out;
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("active unselected");
   property p_hold;
      host_data_oe_out && $past(host_data_oe_out) && $past(host_data_oe_out, 2) |->
         $stable(host_data_out);
   endproperty
   a_hold: assert property (p_hold) else $error("read data moved");
   c_rd: cover property (int_rd_out ##1 host_data_oe_out);
   c_wr: cover property (int_wr_out);
   c_irq: cover property ($rose(host_irq_oe_out));
endmodule : hpb_port_props
bind hpb_port hpb_port_props u_props (.clock_in(clock_in), .rstn_in(rstn_in),
   .host_cs_n_in(host_cs_n_in), .irq_pending_in(irq_pending_in), .host_data_out(host_data_out),
   .host_data_oe_out(host_data_oe_out), .host_irq_n_out(host_irq_n_out),
   .host_irq_oe_out(host_irq_oe_out), .int_wr_out(int_wr_out), .int_rd_out(int_rd_out));

// ==== hpb_cpu_model.sv ====
// Processor model driving the host pins of the port
`timescale 1ns/1ps
module hpb_cpu_model (
   // From the port
   input wire logic clock_in,
   input wire logic [15:0] dut_data_in,
   input wire logic dut_oe_in,
   // Host pins
   output logic cs_n_out,
   output logic rnw_wr_n_out,
   output logic oe_rd_n_out,
   output logic [11:0] addr_out,
   output logic [15:0] bus_out
);
   logic [15:0] cpu_d = 16'h0000;
   logic drv = 1'b0;
   // A released bus shows the inverse, never a stale copy
   assign bus_out = dut_oe_in ? dut_data_in : (drv ? cpu_d : ~cpu_d);
   initial begin
      cs_n_out = 1'b1;
      rnw_wr_n_out = 1'b1;
      oe_rd_n_out = 1'b1;
      addr_out = 12'h000;
   end
   // One access held ten cycles, then ten idle cycles
   task automatic acc(input logic cs_n, input logic st, input logic wr,
      input logic [11:0] a, input logic [15:0] d, output logic [15:0] q);
      @(negedge clock_in);
      cs_n_out = cs_n;
      addr_out = a;
      cpu_d = d;
      drv = wr;
      rnw_wr_n_out = !wr;
      oe_rd_n_out = st ? wr : 1'b0;
      repeat (10) @(negedge clock_in);
      q = bus_out;
      cs_n_out = 1'b1;
      drv = 1'b0;
      rnw_wr_n_out = 1'b1;
      oe_rd_n_out = st;
      repeat (10) @(negedge clock_in);
   endtask : acc
endmodule : hpb_cpu_model

// ==== hpb_port_tb_top.sv ====
// Testbench for the host bus port
`timescale 1ns/1ps
module hpb_port_tb_top;
   logic clock_in, rstn_in, style_strobe_in, irq_pending_in, host_data_oe_out, host_cs_n_in;
   logic host_rnw_wr_n_in, host_oe_rd_n_in, host_irq_n_out, host_irq_oe_out, int_wr_out;
   logic int_rd_out;
   logic [15:0] host_data_in, host_data_out, int_wdata_out, q;
   logic [15:0] int_rdata_in = 16'h0000;
   logic [11:0] host_addr_in, int_addr_out;
   int fail_count = 0, n_checks = 0, n_wr = 0, n_rd = 0, cyc = 0, w0, r0;
   // ****************
   // Clock, parts, monitors
   // ****************
   initial begin
      clock_in = 1'b0;
      forever #25 clock_in = ~clock_in;
   end
   hpb_port u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .style_strobe_in(style_strobe_in),
      .host_addr_in(host_addr_in), .host_data_in(host_data_in), .host_data_out(host_data_out),
      .host_data_oe_out(host_data_oe_out), .host_cs_n_in(host_cs_n_in),
      .host_rnw_wr_n_in(host_rnw_wr_n_in), .host_oe_rd_n_in(host_oe_rd_n_in),
      .host_irq_n_out(host_irq_n_out), .host_irq_oe_out(host_irq_oe_out),
      .irq_pending_in(irq_pending_in), .int_rdata_in(int_rdata_in), .int_wr_out(int_wr_out),
      .int_rd_out(int_rd_out), .int_addr_out(int_addr_out), .int_wdata_out(int_wdata_out));
   hpb_cpu_model u_cpu (.clock_in(clock_in), .dut_data_in(host_data_out),
      .dut_oe_in(host_data_oe_out), .cs_n_out(host_cs_n_in), .rnw_wr_n_out(host_rnw_wr_n_in),
      .oe_rd_n_out(host_oe_rd_n_in), .addr_out(host_addr_in), .bus_out(host_data_in));
   // Internal store answers with an address-keyed pattern
   always @(negedge clock_in) int_rdata_in <= {4'h0, int_addr_out} ^ 16'ha5c3;
   // Pulse counts and hang limit, taken on the falling edge away from the launching edge
   always @(negedge clock_in) begin
      cyc++;
      n_wr += int_wr_out;
      n_rd += int_rd_out;
      if (cyc == 1000) begin
         fail_count++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic t_write(input logic st, input logic [11:0] a, input logic [15:0] d);
      w0 = n_wr;
      u_cpu.acc(1'b0, st, 1'b1, a, d, q);
      chk(16'(n_wr - w0), 16'h0001);
      chk({4'h0, int_addr_out}, {4'h0, a});
      chk(int_wdata_out, d);
   endtask : t_write
   task automatic t_read(input logic st, input logic [11:0] a);
      r0 = n_rd;
      u_cpu.acc(1'b0, st, 1'b0, a, 16'h0000, q);
      chk(q, {4'h0, a} ^ 16'ha5c3);
      chk(16'(n_rd - r0), 16'h0001);
      chk({15'h0, host_data_oe_out}, 16'h0000);
   endtask : t_read
   task automatic t_ignored();
      logic [15:0] wd0;
      wd0 = int_wdata_out;
      w0 = n_wr;
      r0 = n_rd;
      u_cpu.acc(1'b1, 1'b1, 1'b1, 12'h0f0, 16'hbeef, q);
      u_cpu.acc(1'b1, 1'b1, 1'b0, 12'h0f0, 16'h0000, q);
      chk(16'(n_wr + n_rd - w0 - r0), 16'h0000);
      chk(int_wdata_out, wd0);
   endtask : t_ignored
   task automatic t_irq();
      irq_pending_in = 1'b1;
      @(negedge clock_in);
      chk({15'h0, host_irq_oe_out}, 16'h0001);
      chk({15'h0, host_irq_n_out}, 16'h0000);
      irq_pending_in = 1'b0;
      @(negedge clock_in);
      chk({15'h0, host_irq_oe_out}, 16'h0000);
      chk({15'h0, host_irq_n_out}, 16'h0001);
   endtask : t_irq
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   initial begin
      rstn_in = 1'b0;
      style_strobe_in = 1'b1;
      irq_pending_in = 1'b0;
      repeat (10) @(negedge clock_in);
      rstn_in = 1'b1;
      chk({15'h0, host_data_oe_out}, 16'h0000);
      t_write(1'b1, 12'hfff, 16'h8001);
      t_read(1'b1, 12'h000);
      t_write(1'b1, 12'h5a5, 16'h7ffe);
      t_read(1'b1, 12'hfff);
      t_ignored();
      style_strobe_in = 1'b0;
      t_write(1'b0, 12'h123, 16'hc3c3);
      t_read(1'b0, 12'h123);
      t_irq();
      tally_and_finish();
   end
endmodule : hpb_port_tb_top
